/* File: rtl/lmb_pkg.sv */
/*
 * Constants shared by the LCD mode, bank and supply control block.
 * Assumes an APB bus with 32-bit data; registers sit at four times their index.
 */
package lmb_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [11:0] IDX_MODE_BANK = 12'hFB6;
    localparam logic [11:0] IDX_PUMP_WAVE = 12'hFB7;

    // Field positions of lcd_mode_bank_irq_control.
    localparam int BIT_ACTIVE_BANK = 7;
    localparam int BIT_IRQ_SEL     = 6;
    localparam int MODE_HI         = 5;
    localparam int MODE_LO         = 2;
    localparam int BANK_HI         = 1;
    localparam int BANK_LO         = 0;

    // Field positions of lcd_pump_supply_wave_control.
    localparam int BIT_PUMP_TOPO   = 6;
    localparam int BIT_SUPPLY_DIR  = 5;
    localparam int BIT_WAVE_ON     = 4;

    // Reset values.
    localparam logic [6:0] RESET_MODE_BANK = 7'h00;
    localparam logic [2:0] RESET_PUMP_WAVE = 3'h0;

    // Bank source modes.
    localparam logic [1:0] BANK_A     = 2'h0;
    localparam logic [1:0] BANK_B     = 2'h1;
    localparam logic [1:0] BANK_ALT   = 2'h2;
    localparam logic [1:0] BANK_BLANK = 2'h3;

    // Steps of the step tick per frame: eighths, or sixths at one-third duty.
    localparam logic [4:0] STEPS_EIGHTH = 5'h08;
    localparam logic [4:0] STEPS_SIXTH  = 5'h06;
    localparam logic [4:0] ONE_STEP     = 5'h01;
    localparam logic [4:0] TWO_STEPS    = 5'h02;

    // Decoded operating mode.
    typedef struct packed {
        logic [3:0] commons;
        logic       third_duty;
        logic       third_bias;
        logic       type_b;
        logic       static_wave;
        logic       reserved;
    } lmb_mode_type;
endpackage

/* File: rtl/lmb_control.sv */
/*
 * LCD mode, display bank and supply control with deferred register writes.
 * Assumes step_tick_i pulses once per eighth (or sixth) of a frame and that
 * blink_tick_i and blink_blank_i come from the blink rate divider outside.
 */
// The APB register port was left to the implementer.
// Summary of operation
// - Register writes wait in shadows and apply when the current waveform ends.
// - Bit 7 of the mode register reads the active bank: 0 A, 1 B.
// - Frame interrupt at 7/8 frame type A, 7/4 frame type B.
// - At one-third duty the frame interrupt falls at 5/6 or 5/3 frame.
// - Blink interrupt with alternate banks fires on the switch from A to B.
// - Blink interrupt with blinking on fires when segments go displayed to blank.
// - Mode 0000 gives one common, full duty, static bias and waveform.
// - Modes 0001 to 0100 give two commons, half duty, four bias/type pairs.
// - Modes 0101 to 1000 give three commons, one-third duty, same pairs.
// - Modes 1001 to 1100 give four commons, quarter duty, same pairs.
// - Bank mode 00 sources bank A, blinking from the blink field.
// - Bank mode 01 sources bank B, blinking from the blink field.
// - Bank mode 10 alternates banks on the blink divider, starting with A.
// - Bank mode 11 blanks every segment, blink field ignored.
// - Bit 6 selects the pump: 0 tripler, 1 doubler.
// - Bit 5 sets supply pin direction: 0 external input, 1 internal output.
// - Generator off grounds all outputs once the current waveform ends.
`timescale 1ns/100ps
module lmb_control #(
    parameter int ADDR_W = 16
) (
    // Clock and reset.
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    // APB slave.
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // Timing from the prescaler and blink divider.
    input  wire logic              step_tick_i,
    input  wire logic              blink_tick_i,
    input  wire logic              blink_blank_i,
    input  wire logic [1:0]        blink_setting_i,
    // Glass drive control.
    output logic      [3:0]        common_lines_o,
    output logic                   third_duty_o,
    output logic                   third_bias_o,
    output logic                   wave_type_b_o,
    output logic                   static_wave_o,
    output logic                   bank_b_select_o,
    output logic                   segments_blank_o,
    output logic                   outputs_grounded_o,
    output logic                   waveform_end_o,
    // Supply control.
    output logic                   pump_topology_select_o,
    output logic                   glass_supply_direction_o,
    output logic                   waveform_generator_on_o,
    // Interrupt request.
    output logic                   irq_o
);

    // Byte addresses need two bits beyond the register index.
    initial begin
        if (ADDR_W < 14 || ADDR_W > 32) begin
            $error("lmb_control: ADDR_W must lie between 14 and 32");
        end
    end

    typedef struct packed {
        logic [6:0]  pend_mode;
        logic [2:0]  pend_pump;
        logic [6:0]  act_mode;
        logic [2:0]  act_pump;
        logic [4:0]  step;
        logic        bank_b;
        logic        grounded;
        logic        prev_blank;
        logic        irq;
        logic        wave_end;
        logic [31:0] rdata;
    } lmb_state_type;

    lmb_state_type     st;
    lmb_state_type     next_st;
    lmb_pkg::lmb_mode_type mode;

    logic [ADDR_W-1:0] addr_mode;
    logic [ADDR_W-1:0] addr_pump;
    logic              hit_mode;
    logic              hit_pump;
    logic              access;
    logic [4:0]        wave_len;
    logic [4:0]        irq_step;
    logic [1:0]        bank_mode;
    logic              irq_sel;

    assign addr_mode = ADDR_W'({lmb_pkg::IDX_MODE_BANK, 2'b00});
    assign addr_pump = ADDR_W'({lmb_pkg::IDX_PUMP_WAVE, 2'b00});
    assign hit_mode  = (paddr_i == addr_mode);
    assign hit_pump  = (paddr_i == addr_pump);
    assign access    = psel_i & penable_i;
    assign bank_mode = st.act_mode[lmb_pkg::BANK_HI:lmb_pkg::BANK_LO];
    assign irq_sel   = st.act_mode[lmb_pkg::BIT_IRQ_SEL];

    // Operating mode decode of the applied mode field.
    always_comb begin
        mode = '0;
        // Every defined code is spelled out, since bias and type do not follow single code bits.
        case (st.act_mode[lmb_pkg::MODE_HI:lmb_pkg::MODE_LO])
            4'h0: begin
                mode.commons     = 4'h1;
                mode.third_duty  = 1'b0;
                mode.third_bias  = 1'b0;
                mode.type_b      = 1'b0;
                mode.static_wave = 1'b1;
            end
            // Two commons at half duty.
            4'h1: begin
                mode.commons     = 4'h3;
                mode.third_duty  = 1'b0;
                mode.third_bias  = 1'b0;
                mode.type_b      = 1'b0;
                mode.static_wave = 1'b0;
            end
            4'h2: begin
                mode.commons     = 4'h3;
                mode.third_duty  = 1'b0;
                mode.third_bias  = 1'b0;
                mode.type_b      = 1'b1;
                mode.static_wave = 1'b0;
            end
            4'h3: begin
                mode.commons     = 4'h3;
                mode.third_duty  = 1'b0;
                mode.third_bias  = 1'b1;
                mode.type_b      = 1'b0;
                mode.static_wave = 1'b0;
            end
            4'h4: begin
                mode.commons     = 4'h3;
                mode.third_duty  = 1'b0;
                mode.third_bias  = 1'b1;
                mode.type_b      = 1'b1;
                mode.static_wave = 1'b0;
            end
            // Three commons at one-third duty.
            4'h5: begin
                mode.commons     = 4'h7;
                mode.third_duty  = 1'b1;
                mode.third_bias  = 1'b0;
                mode.type_b      = 1'b0;
                mode.static_wave = 1'b0;
            end
            4'h6: begin
                mode.commons     = 4'h7;
                mode.third_duty  = 1'b1;
                mode.third_bias  = 1'b0;
                mode.type_b      = 1'b1;
                mode.static_wave = 1'b0;
            end
            4'h7: begin
                mode.commons     = 4'h7;
                mode.third_duty  = 1'b1;
                mode.third_bias  = 1'b1;
                mode.type_b      = 1'b0;
                mode.static_wave = 1'b0;
            end
            4'h8: begin
                mode.commons     = 4'h7;
                mode.third_duty  = 1'b1;
                mode.third_bias  = 1'b1;
                mode.type_b      = 1'b1;
                mode.static_wave = 1'b0;
            end
            // Four commons at quarter duty.
            4'h9: begin
                mode.commons     = 4'hF;
                mode.third_duty  = 1'b0;
                mode.third_bias  = 1'b0;
                mode.type_b      = 1'b0;
                mode.static_wave = 1'b0;
            end
            4'hA: begin
                mode.commons     = 4'hF;
                mode.third_duty  = 1'b0;
                mode.third_bias  = 1'b0;
                mode.type_b      = 1'b1;
                mode.static_wave = 1'b0;
            end
            4'hB: begin
                mode.commons     = 4'hF;
                mode.third_duty  = 1'b0;
                mode.third_bias  = 1'b1;
                mode.type_b      = 1'b0;
                mode.static_wave = 1'b0;
            end
            4'hC: begin
                mode.commons     = 4'hF;
                mode.third_duty  = 1'b0;
                mode.third_bias  = 1'b1;
                mode.type_b      = 1'b1;
                mode.static_wave = 1'b0;
            end
            default: begin
                // Reserved codes keep the glass undriven but the timing running.
                mode.reserved = 1'b1;
            end
        endcase
    end

    // A type B waveform spans two frames; its interrupt point is two steps early.
    always_comb begin
        wave_len = mode.third_duty ? lmb_pkg::STEPS_SIXTH : lmb_pkg::STEPS_EIGHTH;
        if (mode.type_b) begin
            wave_len = 5'(wave_len << 1);
        end
        irq_step = mode.type_b ? 5'(wave_len - lmb_pkg::TWO_STEPS)
                               : 5'(wave_len - lmb_pkg::ONE_STEP);
    end

    always_comb begin
        logic wave_done;
        logic irq_hit;
        logic blink_on;
        wave_done = 1'b0;
        irq_hit   = 1'b0;
        blink_on  = (blink_setting_i != 2'h0);
        next_st   = st;

        next_st.wave_end   = 1'b0;
        next_st.prev_blank = blink_blank_i;

        // Waveform step counter; the end of a waveform is the apply point.
        if (step_tick_i) begin
            if (st.step >= 5'(wave_len - lmb_pkg::ONE_STEP)) begin
                next_st.step = '0;
                wave_done    = 1'b1;
            end else begin
                next_st.step = 5'(st.step + lmb_pkg::ONE_STEP);
            end
            if (!irq_sel && (next_st.step == irq_step) && !mode.reserved) begin
                irq_hit = 1'b1;
            end
        end

        // Bank sourcing; alternation is paced by the blink divider.
        case (bank_mode)
            lmb_pkg::BANK_A:     next_st.bank_b = 1'b0;
            lmb_pkg::BANK_B:     next_st.bank_b = 1'b1;
            lmb_pkg::BANK_ALT: begin
                if (blink_tick_i) begin
                    next_st.bank_b = ~st.bank_b;
                    if (irq_sel && !st.bank_b) begin
                        irq_hit = 1'b1;
                    end
                end
            end
            default:             next_st.bank_b = st.bank_b;
        endcase

        // Displayed-to-blank edge of the blink phase, only where blinking applies.
        if (irq_sel && blink_on && blink_blank_i && !st.prev_blank &&
            (bank_mode == lmb_pkg::BANK_A || bank_mode == lmb_pkg::BANK_B)) begin
            irq_hit = 1'b1;
        end

        // Shadows become live only at the waveform boundary.
        if (wave_done) begin
            next_st.wave_end = 1'b1;
            next_st.act_mode = st.pend_mode;
            next_st.act_pump = st.pend_pump;
            next_st.grounded = ~st.pend_pump[lmb_pkg::BIT_WAVE_ON - 4];
            // Entering alternation always starts from bank A.
            if (st.pend_mode[lmb_pkg::BANK_HI:lmb_pkg::BANK_LO] == lmb_pkg::BANK_ALT &&
                bank_mode != lmb_pkg::BANK_ALT) begin
                next_st.bank_b = 1'b0;
            end
        end

        next_st.irq = irq_hit;

        // APB write lands in the shadows; reserved bits are not stored.
        if (access && pwrite_i) begin
            if (hit_mode && pstrb_i[0]) begin
                next_st.pend_mode = pwdata_i[6:0];
            end
            if (hit_pump && pstrb_i[0]) begin
                next_st.pend_pump = pwdata_i[lmb_pkg::BIT_PUMP_TOPO:lmb_pkg::BIT_WAVE_ON];
            end
        end

        // Read data: bit 7 shows the live bank, reserved bits read zero.
        next_st.rdata = '0;
        if (psel_i && !penable_i && !pwrite_i) begin
            if (hit_mode) begin
                next_st.rdata[7:0] = {st.bank_b, st.pend_mode};
            end else if (hit_pump) begin
                next_st.rdata[7:0] = {1'b0, st.pend_pump, 4'h0};
            end
        end else if (access) begin
            next_st.rdata = st.rdata;
        end

        if (rst_i) begin
            next_st           = '0;
            next_st.pend_mode = lmb_pkg::RESET_MODE_BANK;
            next_st.act_mode  = lmb_pkg::RESET_MODE_BANK;
            next_st.pend_pump = lmb_pkg::RESET_PUMP_WAVE;
            next_st.act_pump  = lmb_pkg::RESET_PUMP_WAVE;
            next_st.grounded  = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        st <= next_st;
    end

    // The slave always answers in the access cycle; no wait states.
    assign pready_o  = 1'b1;
    assign pslverr_o = access & ~(hit_mode | hit_pump);
    assign prdata_o  = st.rdata;

    assign common_lines_o   = st.grounded ? 4'h0 : mode.commons;
    assign third_duty_o     = mode.third_duty;
    assign third_bias_o     = mode.third_bias;
    assign wave_type_b_o    = mode.type_b;
    assign static_wave_o    = mode.static_wave;
    assign bank_b_select_o  = st.bank_b;
    assign segments_blank_o = (bank_mode == lmb_pkg::BANK_BLANK) | mode.reserved;
    assign outputs_grounded_o = st.grounded;
    assign waveform_end_o   = st.wave_end;

    assign pump_topology_select_o   = st.act_pump[lmb_pkg::BIT_PUMP_TOPO - 4];
    assign glass_supply_direction_o = st.act_pump[lmb_pkg::BIT_SUPPLY_DIR - 4];
    assign waveform_generator_on_o  = st.act_pump[lmb_pkg::BIT_WAVE_ON - 4];
    assign irq_o = st.irq;

endmodule

/* File: sim/lmb_glass_model.sv */
/* Passive segment glass on the common lines of the LCD control block.
   Assumes the commons mask and ground flag come straight from the block. */
`timescale 1ns/100ps
module lmb_glass_model (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] common_lines_i,
    input  wire logic       grounded_i,
    output logic            fault_o
);
    // A gap in the driven commons, or drive while grounded, shows ghost segments.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            fault_o <= 1'b0;
        end else if ((common_lines_i & (common_lines_i + 4'h1)) != 4'h0) begin
            fault_o <= 1'b1;
        end else if (grounded_i && common_lines_i != 4'h0) begin
            fault_o <= 1'b1;
        end
    end
endmodule

/* File: sim/lmb_control_properties.sv */
/* Port-level assertions for the LCD mode, bank and supply control block.
   Assumes it is bound to the block and sees the block's own ports. */
`timescale 1ns/100ps
module lmb_control_checker #(
    parameter int ADDR_W = 16
) (
    input wire logic              clk_sys_i, rst_i, psel_i, penable_i, pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0]       pwdata_i, prdata_o,
    input wire logic [3:0]        pstrb_i, common_lines_o,
    input wire logic [1:0]        blink_setting_i,
    input wire logic              pready_o, pslverr_o, step_tick_i, blink_tick_i, blink_blank_i,
    input wire logic              third_duty_o, third_bias_o, wave_type_b_o, static_wave_o,
    input wire logic              bank_b_select_o, segments_blank_o, outputs_grounded_o,
    input wire logic              waveform_end_o, pump_topology_select_o, irq_o,
    input wire logic              glass_supply_direction_o, waveform_generator_on_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic rd_mode;
    logic rd_pump;
    assign rd_mode = psel_i && penable_i && !pwrite_i &&
        paddr_i == ADDR_W'({lmb_pkg::IDX_MODE_BANK, 2'h0});
    assign rd_pump = psel_i && penable_i && !pwrite_i &&
        paddr_i == ADDR_W'({lmb_pkg::IDX_PUMP_WAVE, 2'h0});
    a_irq_one_cycle: assert property (irq_o |=> !irq_o)
        else $error("irq longer than one cycle");
    a_bank_readback: assert property (rd_mode |-> prdata_o[7] == $past(bank_b_select_o))
        else $error("bank status bit wrong");
    a_reserved_read: assert property (rd_pump |-> prdata_o[7] == 1'b0 && prdata_o[3:0] == 4'h0)
        else $error("reserved bits not zero");
    a_pump_deferred: assert property (!$stable({pump_topology_select_o, glass_supply_direction_o,
        waveform_generator_on_o}) |-> ##[0:1] waveform_end_o) else $error("pump bits early");
    a_mode_deferred: assert property (!$stable({third_duty_o, third_bias_o, wave_type_b_o,
        static_wave_o}) |-> ##[0:1] waveform_end_o) else $error("mode applied early");
    a_ground_deferred: assert property (!$stable(outputs_grounded_o) |-> ##[0:1] waveform_end_o)
        else $error("ground change early");
    a_ground_commons: assert property (outputs_grounded_o |-> common_lines_o == 4'h0)
        else $error("commons driven while grounded");
    a_static_one: assert property (static_wave_o && !outputs_grounded_o |->
        common_lines_o == 4'h1 && !wave_type_b_o) else $error("static mode wrong");
    a_third_three: assert property (third_duty_o && !outputs_grounded_o |-> common_lines_o == 4'h7)
        else $error("third duty commons wrong");
    a_commons_legal: assert property (common_lines_o inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
        else $error("commons mask illegal");
    c_irq: cover property (irq_o);
    c_bank_b: cover property ($rose(bank_b_select_o));
    c_ground_end: cover property (waveform_end_o && outputs_grounded_o);
endmodule

/* File: sim/testbench.sv */
/* Self-checking bench for the LCD mode, bank and supply control block.
   Assumes the package, block, glass model and checker are compiled first. */
`timescale 1ns/100ps
module testbench;
    logic        clk_sys_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
    logic        pwrite_i = 1'b0, step_tick_i = 1'b0, blink_tick_i = 1'b0, blink_blank_i = 1'b0;
    logic [15:0] paddr_i = 16'h0000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [3:0]  pstrb_i = 4'hF, common_lines_o;
    logic [1:0]  blink_setting_i = 2'h0;
    logic        pready_o, pslverr_o, third_duty_o, third_bias_o, wave_type_b_o, static_wave_o;
    logic        bank_b_select_o, segments_blank_o, outputs_grounded_o, waveform_end_o, irq_o;
    logic        pump_topology_select_o, glass_supply_direction_o, waveform_generator_on_o;
    logic        er, glass_fault;
    int          failures = 0, checked = 0, cycles = 0;
    localparam logic [15:0] AM = {2'h0, lmb_pkg::IDX_MODE_BANK, 2'h0};
    localparam logic [15:0] AP = {2'h0, lmb_pkg::IDX_PUMP_WAVE, 2'h0};
    lmb_control #(.ADDR_W(16)) u_lmb_control (.*);
    lmb_glass_model u_lmb_glass_model (.clk_sys_i, .rst_i, .common_lines_i(common_lines_o),
        .grounded_i(outputs_grounded_o), .fault_o(glass_fault));
    initial forever #10 clk_sys_i = ~clk_sys_i;
    // The ceiling is several times the longest expected run.
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic complete_run();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // Pulses a tick input or toggles blink_blank_i, and gathers irq and waveform end over the next four cycles.
    task automatic pulse(input int what, output logic irq_seen, output logic end_seen);
        irq_seen = 1'b0;
        end_seen = 1'b0;
        @(posedge clk_sys_i);
        if (what == 0) step_tick_i <= 1'b1;
        else if (what == 1) blink_tick_i <= 1'b1;
        else blink_blank_i <= ~blink_blank_i;
        repeat (4) begin
            @(posedge clk_sys_i);
            step_tick_i <= 1'b0;
            blink_tick_i <= 1'b0;
            #1;
            irq_seen = irq_seen | irq_o;
            end_seen = end_seen | waveform_end_o;
        end
    endtask
    task automatic apply();
        logic i;
        logic e;
        e = 1'b0;
        for (int n = 0; n < 40 && e !== 1'b1; n++) pulse(0, i, e);
        check({31'h0, e}, 32'h1);
    endtask
    function automatic logic [31:0] mode_exp(input int m);
        logic [3:0] c;
        c = (m == 0) ? 4'h1 : (m < 5) ? 4'h3 : (m < 9) ? 4'h7 : 4'hF;
        return {24'h0, c, m > 4 && m < 9, m != 0 && (m - 1) % 4 > 1, m != 0 && (m - 1) % 2 == 1,
            m == 0};
    endfunction
    function automatic int irq_steps(input int m);
        int len;
        len = (m > 4 && m < 9) ? 6 : 8;
        return (m != 0 && (m - 1) % 2 == 1) ? 2 * len - 2 : len - 1;
    endfunction
    initial begin
        logic       i;
        logic       e;
        logic [2:0] p;
        logic [2:0] q;
        int         n;
        int         pm;
        n = $urandom(32'hBBE762FE);
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        apb(1'b0, AM, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, AP, 32'h10);
        check({31'h0, outputs_grounded_o}, 32'h1);
        apply();
        check({31'h0, outputs_grounded_o}, 32'h0);
        $display("test enable done");
        pm = 0;
        for (int m = 0; m < 13; m++) begin
            apb(1'b1, AM, 32'(m << 2));
            check(mode_exp(pm), {24'h0, common_lines_o, third_duty_o, third_bias_o,
                wave_type_b_o, static_wave_o});
            apply();
            check(mode_exp(m), {24'h0, common_lines_o, third_duty_o, third_bias_o,
                wave_type_b_o, static_wave_o});
            n = 0;
            i = 1'b0;
            while (i !== 1'b1 && n < 40) begin
                pulse(0, i, e);
                n++;
            end
            check(n, irq_steps(m));
            pm = m;
        end
        apb(1'b1, AM, 32'h34);
        apply();
        check({27'h0, segments_blank_o, common_lines_o}, 32'h10);
        $display("test modes done");
        blink_setting_i <= 2'($urandom_range(3, 1));
        apb(1'b1, AM, 32'h45);
        apply();
        apb(1'b0, AM, 32'h0);
        check(rd, 32'hC5);
        apb(1'b1, AM, 32'h44);
        apply();
        pulse(2, i, e);
        check({30'h0, bank_b_select_o, i}, 32'h1);
        pulse(2, i, e);
        check({31'h0, i}, 32'h0);
        apb(1'b1, AM, 32'h46);
        apply();
        check({31'h0, bank_b_select_o}, 32'h0);
        pulse(1, i, e);
        check({30'h0, bank_b_select_o, i}, 32'h3);
        pulse(1, i, e);
        check({30'h0, bank_b_select_o, i}, 32'h0);
        apb(1'b1, AM, 32'h07);
        apply();
        check({31'h0, segments_blank_o}, 32'h1);
        $display("test banks done");
        q = 3'h1;
        repeat (4) begin
            p = 3'($urandom);
            apb(1'b1, AP, {25'h0, p, 4'h0});
            check({29'h0, pump_topology_select_o, glass_supply_direction_o,
                waveform_generator_on_o}, {29'h0, q});
            apply();
            check({28'h0, pump_topology_select_o, glass_supply_direction_o,
                waveform_generator_on_o, outputs_grounded_o}, {28'h0, p, ~p[0]});
            apb(1'b0, AP, 32'h0);
            check(rd, {25'h0, p, 4'h0});
            q = p;
        end
        apb(1'b0, 16'h0000, 32'h0);
        check({er, rd[30:0]}, 32'h80000000);
        check({31'h0, glass_fault}, 32'h0);
        $display("test supply done");
        complete_run();
    end
endmodule
bind lmb_control lmb_control_checker #(.ADDR_W(ADDR_W)) u_lmb_control_checker (.*);
